// File: include/ksn_consts.svh
// constants of the keyboard source and scan nmi block
// assumes inclusion by bare name from the checker and the design modules
`ifndef KSN_CONSTS_SVH
`define KSN_CONSTS_SVH

// register indices, byte address is four times the index
`define KSN_IDX_PORT_DATA   8'h60
`define KSN_IDX_SCAN_CFG    8'h66
`define KSN_IDX_NMI_CTRL    8'h67
`define KSN_IDX_SHADOW      8'h68
`define KSN_IDX_DRIVE       8'h69
`define KSN_IDX_LINES       8'h6a

// field positions of the nmi control and status register
`define KSN_BIT_KEY_FLAG    7
`define KSN_BIT_SCAN_FLAG   6
`define KSN_BIT_TRAP_FLAG   5
`define KSN_BIT_KEY_EN      3
`define KSN_BIT_PER_EN      2
`define KSN_BIT_TRAP_EN     1

// reset values
`define KSN_RST_SCAN_CFG    8'h00
`define KSN_RST_BYTE        8'h00
`define KSN_RST_LINES       24'hffffff
`define KSN_RST_DRIVE       24'h000000

// periodic nmi rates in hz and the clock rate
`define KSN_CLK_HZ          200000000
`define KSN_RATE0_HZ        51
`define KSN_RATE1_HZ        64
`define KSN_RATE2_HZ        85
`define KSN_RATE3_HZ        128
`define KSN_RATE_CYC(hz)    ((`KSN_CLK_HZ) / (hz))
`define KSN_RATE_CNT_W      22

`endif

// File: include/ksn_pkg.sv
// types shared by the keyboard source and scan nmi block
// assumes ksn_consts.svh on the include path
package ksn_pkg;

  // keyboard scan enable register layout
  typedef struct packed {
    logic [3:0] switches;
    logic       primary_source_select;
    logic       matrix_sense_select;
    logic [1:0] periodic_rate_sel;
  } ksn_scan_cfg_type;

  // enable bits of the nmi control register
  typedef struct packed {
    logic keydown_nmi_enable;
    logic periodic_nmi_enable;
    logic port_b_trap_enable;
  } ksn_nmi_en_type;

  // register decode result
  typedef struct packed {
    logic       hit;
    logic [7:0] index;
  } ksn_decode_type;

  // apb slave phases, one-hot
  typedef enum logic [1:0] {
    KSN_BUS_IDLE = 2'b01,
    KSN_BUS_ACK  = 2'b10
  } ksn_bus_state_type;

endpackage

// File: testbench/ksn_kbd_matrix.sv
// keyboard matrix at the far side of the scan pins
// assumes open drain drive pins with pull-downs and return lines with pull-ups
`timescale 1ns/1ps

module ksn_kbd_matrix (
  input  wire logic [23:0] drive_out,
  input  wire logic [23:0] drive_oe,
  input  wire logic [23:0] key,
  output logic      [23:0] ret_pin,
  output logic      [23:0] drive_pin
);
  // a pressed key pulls its return low while any drive line is output-enabled
  assign ret_pin = ~(key & {24{|drive_oe}});
  // driven pins follow the design, released pins show the key contact
  assign drive_pin = (drive_oe & drive_out) | (~drive_oe & key);
endmodule

// File: testbench/ksn_top_chk.sv
// assertions on the ports of the keyboard scan nmi block
// assumes byte address four times the index; ce drops only while the bus is idle
`timescale 1ns/1ps
`include "ksn_consts.svh"

module ksn_top_chk
  import ksn_pkg::*;
#(
  parameter logic [`KSN_RATE_CNT_W-1:0] PERIOD0_CYC = 22'd20
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        serial_char_valid,
  input wire logic [23:0] matrix_return_lines,
  input wire logic [23:0] matrix_drive_oe,
  input wire logic [23:0] matrix_drive_out,
  input wire logic        irq1,
  input wire logic        nmi
);
  localparam int PMAX = PERIOD0_CYC + 4;
  logic        wr;
  logic        src_reg;
  logic        sen_reg;
  logic        ken_reg;
  logic        pen_reg;
  logic [23:0] drv_reg;

  // write commit, then copies of the mode and enable bits
  assign wr = psel && penable && pready && pwrite;
  always_ff @(posedge clk) begin
    if (reset) begin
      src_reg <= 1'b0;
      sen_reg <= 1'b0;
      ken_reg <= 1'b0;
      pen_reg <= 1'b0;
      drv_reg <= 24'h0;
    end else if (wr && paddr == 12'h198) begin
      src_reg <= pwdata[3];
      sen_reg <= pwdata[2];
    end else if (wr && paddr == 12'h19c) begin
      ken_reg <= pwdata[3];
      pen_reg <= pwdata[2];
    end else if (wr && paddr == 12'h1a4) begin
      drv_reg <= pwdata[23:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // interrupt sources
  chk_port_irq: assert property (
    wr && paddr == 12'h180 && src_reg |=> irq1) else $error("no irq1 on port write");
  chk_write_quiet: assert property (
    wr && paddr == 12'h180 && !src_reg && !serial_char_valid |=> !irq1)
    else $error("irq1 on serial mode port write");
  chk_serial_irq: assert property (
    ce && serial_char_valid && !src_reg |=> irq1) else $error("no irq1 on serial byte");
  chk_serial_quiet: assert property (
    serial_char_valid && src_reg && !(wr && paddr == 12'h180) |=> !irq1)
    else $error("irq1 on polled serial byte");
  // drive pins and register fields
  chk_drive_mirror: assert property (
    wr && paddr == 12'h1a4 |-> ##[1:3] (matrix_drive_oe == drv_reg && matrix_drive_out == 24'h0))
    else $error("drive pins do not follow register");
  chk_reserved_zero: assert property (
    pready && !pwrite && paddr == 12'h19c |-> prdata[5:4] == 2'b00 && !prdata[0]
    && prdata[3:2] == {ken_reg, pen_reg}) else $error("nmi control readback wrong");
  // nmi behaviour
  chk_quiet_off: assert property (
    !ken_reg && !pen_reg && !nmi |=> !nmi) else $error("nmi while disabled");
  chk_clear_nmi: assert property (
    wr && paddr == 12'h19c && pwdata[7:6] == 2'b11 && !ken_reg && !pen_reg |=> !nmi)
    else $error("nmi not cleared");
  chk_key_level: assert property (
    (ken_reg && !sen_reg && matrix_return_lines != 24'hffffff) [*5] |-> nmi)
    else $error("keydown nmi missing");
  chk_periodic_bound: assert property (
    pen_reg && !ken_reg |-> ##[0:PMAX] nmi) else $error("periodic nmi missing");

  cover property (irq1);
  cover property (nmi && ken_reg);
  cover property (nmi && pen_reg && !ken_reg);
endmodule

bind ksn_top ksn_top_chk #(.PERIOD0_CYC(PERIOD0_CYC)) i_chk (
  .clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .serial_char_valid(serial_char_valid), .matrix_return_lines(matrix_return_lines),
  .matrix_drive_oe(matrix_drive_oe), .matrix_drive_out(matrix_drive_out),
  .irq1(irq1), .nmi(nmi)
);

// File: testbench/ksn_top_tb_top.sv
// self-checking bench for the keyboard scan nmi block
// assumes the checker is bound in and the matrix model sits on the scan pins
`timescale 1ns/1ps

module ksn_top_tb_top;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic        scv = 1'b0;
  logic [7:0]  sch = 8'h0;
  logic [23:0] key = 24'h0;
  logic [31:0] q;
  logic        e;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         irq1;
  wire         nmi;
  wire  [23:0] ret;
  wire  [23:0] drv_in;
  wire  [23:0] drv_out;
  wire  [23:0] drv_oe;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          irq_n = 0;
  int          seed = 3547;
  logic [31:0] per_tab [4] = '{32'd20, 32'd16, 32'd12, 32'd8};

  ksn_top #(.PERIOD0_CYC(22'd20), .PERIOD1_CYC(22'd16), .PERIOD2_CYC(22'd12),
    .PERIOD3_CYC(22'd8)) i_dut (
    .clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_char_valid(scv), .serial_char(sch),
    .matrix_return_lines(ret), .matrix_drive_in(drv_in), .matrix_drive_out(drv_out),
    .matrix_drive_oe(drv_oe), .irq1(irq1), .nmi(nmi));
  ksn_kbd_matrix i_kbd (.drive_out(drv_out), .drive_oe(drv_oe), .key(key),
    .ret_pin(ret), .drive_pin(drv_in));

  // clock, cycle count, irq pulse count and hang limit
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq1 === 1'b1) irq_n <= irq_n + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(q, exp);
  endtask

  // one serial byte pulse, then the data lines change
  task automatic ser(input logic [7:0] b);
    @(posedge clk);
    scv <= 1'b1;
    sch <= b;
    @(posedge clk);
    scv <= 1'b0;
    sch <= ~b;
    repeat (3) @(posedge clk);
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
  endtask

  // cycles between two periodic nmi rises, each after a clear
  task automatic per(input logic [1:0] r, input logic [31:0] p);
    int t0;
    apb(1'b1, 8'h66, {28'h0, 1'b0, r[0], r});
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 8'h67, 32'h44);
      while (nmi !== 1'b0) @(posedge clk);
      while (nmi !== 1'b1) @(posedge clk);
      if (i == 0) t0 = cyc;
    end
    chk(32'(cyc - t0), p);
    apb(1'b1, 8'h67, 32'h40);
    $display("test periodic rate %0d done", r);
  endtask

  initial begin
    logic [7:0] b;
    logic [7:0] w;
    int         i0;
    int         k;
    do_reset();
    for (int r = 3; r >= 0; r--) per(2'(r), per_tab[r]);
    // second reset, reset values, reserved bits, unmapped place
    do_reset();
    rd(8'h66, 32'h0);
    rd(8'h67, 32'h0);
    rd(8'h6a, 32'h00ffffff);
    apb(1'b0, 8'h70, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'h67, 32'h0b);
    rd(8'h67, 32'h0a);
    apb(1'b1, 8'h67, 32'h0);
    // a byte that arrives while ce is low must leave no trace
    ce <= 1'b0;
    i0 = irq_n;
    ser(8'ha5);
    ce <= 1'b1;
    chk(32'(irq_n - i0), 32'd0);
    rd(8'h60, 32'h0);
    $display("test registers done");
    // both keyboard sources with random bytes
    for (int n = 0; n < 3; n++) begin
      b = 8'($random(seed));
      w = 8'($random(seed));
      apb(1'b1, 8'h66, 32'h0);
      i0 = irq_n;
      ser(b);
      chk(32'(irq_n - i0), 32'd1);
      rd(8'h60, {24'h0, b});
      i0 = irq_n;
      apb(1'b1, 8'h60, {24'h0, w});
      rd(8'h68, {24'h0, w});
      chk(32'(irq_n - i0), 32'd0);
      rd(8'h60, {24'h0, b});
      apb(1'b1, 8'h66, 32'h08);
      i0 = irq_n;
      apb(1'b1, 8'h60, {24'h0, w});
      rd(8'h60, {24'h0, w});
      chk(32'(irq_n - i0), 32'd1);
      i0 = irq_n;
      ser(~b);
      chk(32'(irq_n - i0), 32'd0);
      rd(8'h68, {24'h0, ~b});
    end
    $display("test keyboard sources done");
    // keydown in full scan, then partial scan
    for (int m = 0; m < 2; m++) begin
      k = {$random(seed)} % 24;
      apb(1'b1, 8'h66, 32'(m) << 2);
      apb(1'b1, 8'h69, (m == 0) ? 32'h00ffffff : 32'h0);
      key <= 24'h1 << k;
      apb(1'b1, 8'h67, 32'h08);
      repeat (6) @(posedge clk);
      rd(8'h67, 32'h88);
      if (m == 0) rd(8'h6a, {8'h00, ~(24'h1 << k)});
      apb(1'b1, 8'h67, 32'h88);
      rd(8'h67, 32'h88);
      key <= 24'h0;
      repeat (4) @(posedge clk);
      // disable first, then clear both flags with the enables off
      apb(1'b1, 8'h67, 32'h00);
      apb(1'b1, 8'h67, 32'hc0);
      rd(8'h67, 32'h0);
      $display("test keydown mode %0d done", m);
    end
    test_done();
  end
endmodule

// File: verilog/ksn_rate_gen.sv
// periodic tick generator for the scan nmi
// assumes clk, reset and ce of the top; periods given in clock cycles
`timescale 1ns/1ps
`include "ksn_consts.svh"

module ksn_rate_gen
  import ksn_pkg::*;
#(
  parameter logic [`KSN_RATE_CNT_W-1:0] PERIOD0 = 22'(`KSN_RATE_CYC(`KSN_RATE0_HZ)),
  parameter logic [`KSN_RATE_CNT_W-1:0] PERIOD1 = 22'(`KSN_RATE_CYC(`KSN_RATE1_HZ)),
  parameter logic [`KSN_RATE_CNT_W-1:0] PERIOD2 = 22'(`KSN_RATE_CYC(`KSN_RATE2_HZ)),
  parameter logic [`KSN_RATE_CNT_W-1:0] PERIOD3 = 22'(`KSN_RATE_CYC(`KSN_RATE3_HZ))
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic [1:0] rate_sel,
  output logic            tick
);

  logic [`KSN_RATE_CNT_W-1:0] cnt_reg;
  logic [`KSN_RATE_CNT_W-1:0] cnt_next;
  logic [`KSN_RATE_CNT_W-1:0] limit;
  logic                       tick_reg;
  logic                       tick_next;

  // free running, so an enable may see a tick at once
  always_comb begin
    case (rate_sel)
      2'b00:   limit = PERIOD0;
      2'b01:   limit = PERIOD1;
      2'b10:   limit = PERIOD2;
      default: limit = PERIOD3;
    endcase
    // >= catches a count left above a shorter new period
    if (cnt_reg >= limit - 22'h000001) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end else begin
      cnt_next  = cnt_reg + 22'h000001;
      tick_next = 1'b0;
    end
  end

  // counter and tick registers
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (ce) begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

// File: verilog/ksn_top.sv
// keyboard source selection and scan nmi logic with an apb register slave
// assumes matrix pins arrive asynchronously and serial bytes come on clk
`timescale 1ns/1ps
`include "ksn_consts.svh"

module ksn_top
  import ksn_pkg::*;
#(
  parameter logic [`KSN_RATE_CNT_W-1:0] PERIOD0_CYC = 22'(`KSN_RATE_CYC(`KSN_RATE0_HZ)),
  parameter logic [`KSN_RATE_CNT_W-1:0] PERIOD1_CYC = 22'(`KSN_RATE_CYC(`KSN_RATE1_HZ)),
  parameter logic [`KSN_RATE_CNT_W-1:0] PERIOD2_CYC = 22'(`KSN_RATE_CYC(`KSN_RATE2_HZ)),
  parameter logic [`KSN_RATE_CNT_W-1:0] PERIOD3_CYC = 22'(`KSN_RATE_CYC(`KSN_RATE3_HZ))
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_char_valid,
  input  wire logic [7:0]  serial_char,
  input  wire logic [23:0] matrix_return_lines,
  input  wire logic [23:0] matrix_drive_in,
  output logic      [23:0] matrix_drive_out,
  output logic      [23:0] matrix_drive_oe,
  output logic             irq1,
  output logic             nmi
);

  // map a byte address onto a register index
  function automatic ksn_decode_type ksn_decode(input logic [11:0] addr);
    ksn_decode_type d;
    d.index = addr[9:2];
    d.hit   = (addr[11:10] == 2'b00) && (addr[1:0] == 2'b00) &&
              ((d.index == `KSN_IDX_PORT_DATA) || (d.index == `KSN_IDX_SCAN_CFG) ||
               (d.index == `KSN_IDX_NMI_CTRL)  || (d.index == `KSN_IDX_SHADOW)   ||
               (d.index == `KSN_IDX_DRIVE)     || (d.index == `KSN_IDX_LINES));
    return d;
  endfunction

  // per-line edge detect between two samples
  function automatic logic [23:0] ksn_edges(input logic [23:0] prev,
                                            input logic [23:0] cur,
                                            input logic        rising);
    return rising ? (cur & ~prev) : (prev & ~cur);
  endfunction

  ksn_bus_state_type bus_state_reg;
  ksn_bus_state_type bus_state_next;
  logic [31:0]       prdata_reg;
  logic [31:0]       prdata_next;
  logic              pslverr_reg;
  logic              pslverr_next;
  logic              pready_reg;
  logic              pready_next;
  ksn_decode_type    dec;
  logic              commit_wr;
  logic [7:0]        wbyte;

  ksn_scan_cfg_type  scan_cfg_reg;
  ksn_scan_cfg_type  scan_cfg_next;
  ksn_nmi_en_type    nmi_en_reg;
  ksn_nmi_en_type    nmi_en_next;
  logic [7:0]        port_data_reg;
  logic [7:0]        port_data_next;
  logic [7:0]        serial_code_reg;
  logic [7:0]        serial_code_next;
  logic [7:0]        shadow_reg;
  logic [7:0]        shadow_next;
  logic [23:0]       drive_reg;
  logic [23:0]       drive_next;

  logic [23:0]       ret_meta_reg;
  logic [23:0]       ret_sync_reg;
  logic [23:0]       ret_prev_reg;
  logic [23:0]       drv_meta_reg;
  logic [23:0]       drv_sync_reg;
  logic [23:0]       drv_prev_reg;

  logic              key_flag_reg;
  logic              key_flag_next;
  logic              scan_flag_reg;
  logic              scan_flag_next;
  logic              irq1_reg;
  logic              irq1_next;
  logic              nmi_reg;
  logic              nmi_next;
  logic [23:0]       drive_oe_reg;
  logic [23:0]       drive_out_reg;

  logic              rate_tick;
  logic              key_cond;
  logic              key_edge;
  logic              key_set;
  logic              scan_set;
  logic [7:0]        ctrl_read;

  // apb slave: one wait state, write commits on the ready edge
  always_comb begin
    dec            = ksn_decode(paddr);
    bus_state_next = bus_state_reg;
    prdata_next    = prdata_reg;
    pslverr_next   = 1'b0;
    pready_next    = 1'b0;
    case (bus_state_reg)
      KSN_BUS_IDLE: begin
        if (psel && penable) begin
          bus_state_next = KSN_BUS_ACK;
          pready_next    = 1'b1;
          pslverr_next   = ~dec.hit;
          prdata_next    = '0;
          if (!pwrite && dec.hit) begin
            case (dec.index)
              // port read follows the selected primary source
              `KSN_IDX_PORT_DATA: prdata_next[7:0] = scan_cfg_reg.primary_source_select ?
                                                     port_data_reg : serial_code_reg;
              `KSN_IDX_SCAN_CFG:  prdata_next[7:0] = scan_cfg_reg;
              `KSN_IDX_NMI_CTRL:  prdata_next[7:0] = ctrl_read;
              `KSN_IDX_SHADOW:    prdata_next[7:0] = shadow_reg;
              `KSN_IDX_DRIVE:     prdata_next[23:0] = drive_reg;
              `KSN_IDX_LINES:     prdata_next[23:0] = ret_sync_reg;
              default:            prdata_next = '0;
            endcase
          end
        end
      end
      KSN_BUS_ACK: begin
        bus_state_next = KSN_BUS_IDLE;
      end
      default: begin
        bus_state_next = KSN_BUS_IDLE;
      end
    endcase
  end

  // write strobe, only at the edge where ready is seen high
  assign commit_wr = (bus_state_reg == KSN_BUS_ACK) && psel && penable && pwrite && dec.hit;
  assign wbyte     = pwdata[7:0];

  // status register view
  always_comb begin
    ctrl_read                     = 8'h00;
    ctrl_read[`KSN_BIT_KEY_FLAG]  = key_flag_reg;
    ctrl_read[`KSN_BIT_SCAN_FLAG] = scan_flag_reg;
    ctrl_read[`KSN_BIT_KEY_EN]    = nmi_en_reg.keydown_nmi_enable;
    ctrl_read[`KSN_BIT_PER_EN]    = nmi_en_reg.periodic_nmi_enable;
    ctrl_read[`KSN_BIT_TRAP_EN]   = nmi_en_reg.port_b_trap_enable;
  end

  // bus registers
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_state_reg <= KSN_BUS_IDLE;
      prdata_reg    <= '0;
      pslverr_reg   <= 1'b0;
      pready_reg    <= 1'b0;
    end else if (ce) begin
      bus_state_reg <= bus_state_next;
      prdata_reg    <= prdata_next;
      pslverr_reg   <= pslverr_next;
      pready_reg    <= pready_next;
    end
  end

  // software-written configuration and data bytes
  always_comb begin
    scan_cfg_next    = scan_cfg_reg;
    nmi_en_next      = nmi_en_reg;
    port_data_next   = port_data_reg;
    serial_code_next = serial_code_reg;
    shadow_next      = shadow_reg;
    drive_next       = drive_reg;
    if (commit_wr) begin
      case (dec.index)
        `KSN_IDX_SCAN_CFG: scan_cfg_next = wbyte;
        `KSN_IDX_NMI_CTRL: begin
          nmi_en_next.keydown_nmi_enable  = wbyte[`KSN_BIT_KEY_EN];
          nmi_en_next.periodic_nmi_enable = wbyte[`KSN_BIT_PER_EN];
          nmi_en_next.port_b_trap_enable  = wbyte[`KSN_BIT_TRAP_EN];
        end
        `KSN_IDX_PORT_DATA: begin
          if (scan_cfg_reg.primary_source_select) begin
            port_data_next = wbyte;
          end else begin
            shadow_next = wbyte;
          end
        end
        `KSN_IDX_SHADOW:   shadow_next = wbyte;
        `KSN_IDX_DRIVE:    drive_next  = pwdata[23:0];
        default:           drive_next  = drive_reg;
      endcase
    end
    // a received byte wins over a host write in the same cycle
    if (serial_char_valid) begin
      if (scan_cfg_reg.primary_source_select) begin
        shadow_next = serial_char;
      end else begin
        serial_code_next = serial_char;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (reset) begin
      scan_cfg_reg    <= `KSN_RST_SCAN_CFG;
      nmi_en_reg      <= '0;
      port_data_reg   <= `KSN_RST_BYTE;
      serial_code_reg <= `KSN_RST_BYTE;
      shadow_reg      <= `KSN_RST_BYTE;
      drive_reg       <= `KSN_RST_DRIVE;
    end else if (ce) begin
      scan_cfg_reg    <= scan_cfg_next;
      nmi_en_reg      <= nmi_en_next;
      port_data_reg   <= port_data_next;
      serial_code_reg <= serial_code_next;
      shadow_reg      <= shadow_next;
      drive_reg       <= drive_next;
    end
  end

  // two-stage synchronisers and previous samples for the matrix pins
  always_ff @(posedge clk) begin
    if (reset) begin
      ret_meta_reg <= `KSN_RST_LINES;
      ret_sync_reg <= `KSN_RST_LINES;
      ret_prev_reg <= `KSN_RST_LINES;
      drv_meta_reg <= `KSN_RST_DRIVE;
      drv_sync_reg <= `KSN_RST_DRIVE;
      drv_prev_reg <= `KSN_RST_DRIVE;
    end else if (ce) begin
      ret_meta_reg <= matrix_return_lines;
      ret_sync_reg <= ret_meta_reg;
      ret_prev_reg <= ret_sync_reg;
      drv_meta_reg <= matrix_drive_in;
      drv_sync_reg <= drv_meta_reg;
      drv_prev_reg <= drv_sync_reg;
    end
  end

  // periodic source, free of the scan mode
  ksn_rate_gen #(
    .PERIOD0 (PERIOD0_CYC),
    .PERIOD1 (PERIOD1_CYC),
    .PERIOD2 (PERIOD2_CYC),
    .PERIOD3 (PERIOD3_CYC)
  ) u_rate (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .rate_sel (scan_cfg_reg.periodic_rate_sel),
    .tick     (rate_tick)
  );

  // keydown sense on the lines the mode selects
  always_comb begin
    if (scan_cfg_reg.matrix_sense_select) begin
      key_cond = |drv_sync_reg;
      key_edge = |ksn_edges(drv_prev_reg, drv_sync_reg, 1'b1);
    end else begin
      key_cond = ~&ret_sync_reg;
      key_edge = |ksn_edges(ret_prev_reg, ret_sync_reg, 1'b0);
    end
  end

  assign key_set  = nmi_en_reg.keydown_nmi_enable && (key_edge || key_cond);
  assign scan_set = nmi_en_reg.periodic_nmi_enable && rate_tick;

  // nmi flags, a set in the clearing cycle wins
  always_comb begin
    key_flag_next  = key_flag_reg;
    scan_flag_next = scan_flag_reg;
    if (commit_wr && dec.index == `KSN_IDX_NMI_CTRL) begin
      if (wbyte[`KSN_BIT_KEY_FLAG]) begin
        key_flag_next = 1'b0;
      end
      if (wbyte[`KSN_BIT_SCAN_FLAG]) begin
        scan_flag_next = 1'b0;
      end
    end
    if (key_set) begin
      key_flag_next = 1'b1;
    end
    if (scan_set) begin
      scan_flag_next = 1'b1;
    end
    nmi_next = key_flag_next || scan_flag_next;
  end

  // irq1 source follows the primary interface
  always_comb begin
    if (scan_cfg_reg.primary_source_select) begin
      irq1_next = commit_wr && (dec.index == `KSN_IDX_PORT_DATA);
    end else begin
      irq1_next = serial_char_valid;
    end
  end

  // event and pin registers
  always_ff @(posedge clk) begin
    if (reset) begin
      key_flag_reg  <= 1'b0;
      scan_flag_reg <= 1'b0;
      nmi_reg       <= 1'b0;
      irq1_reg      <= 1'b0;
      drive_oe_reg  <= `KSN_RST_DRIVE;
      drive_out_reg <= `KSN_RST_DRIVE;
    end else if (ce) begin
      key_flag_reg  <= key_flag_next;
      scan_flag_reg <= scan_flag_next;
      nmi_reg       <= nmi_next;
      irq1_reg      <= irq1_next;
      drive_oe_reg  <= drive_next;
      drive_out_reg <= `KSN_RST_DRIVE; // open drain, only ever pulls low
    end
  end

  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign matrix_drive_out = drive_out_reg;
  assign matrix_drive_oe  = drive_oe_reg;
  assign irq1             = irq1_reg;
  assign nmi              = nmi_reg;

endmodule
